// File: rtl/sync_enc_cfg.svh
`ifndef SYNC_ENC_CFG_SVH
`define SYNC_ENC_CFG_SVH
// symbols per superframe period, data symbols between sync symbols
`define SYMS_PER_PERIOD 257
`define DATA_SYMS 256
// sync training signal: symbols per segment, segments
`define TRAIN_SEG_LEN 5
`define TRAIN_SEGS 3
// sync frame bit value for the all-ones pattern
`define FRAME_ONES 1'b1
// 4-QAM bit pair to constellation: 0 maps to +1, 1 to -1
`define QAM_UNIT_W 16
`endif

// File: rtl/sync_enc_pkg.sv
package sync_enc_pkg;
   typedef enum logic [1:0] {
      MODE_IDLE = 2'b00,
      MODE_TRAIN = 2'b01,
      MODE_SHOW = 2'b10
   } enc_mode_e;
   typedef logic [1:0] quad_t;
endpackage

// File: rtl/tone_point_if.sv
`timescale 1ns/100ps
interface tone_point_if #(parameter int W = 16);
   logic valid;
   logic frameBit;
   logic [1:0] rot;
   logic active;
   logic supported;
   logic masked;
   logic initMode;
   logic [W-1:0] gain;
   logic [W-1:0] psdScale;
   logic [W-1:0] outX;
   logic [W-1:0] outY;
   logic outValid;
   modport ctrl(output valid, frameBit, rot, active, supported, masked, initMode, gain, psdScale,
                input outX, outY, outValid);
   modport mapper(input valid, frameBit, rot, active, supported, masked, initMode, gain, psdScale,
                  output outX, outY, outValid);
endinterface

// File: rtl/sync_tone_mapper.sv
`timescale 1ns/100ps
`include "sync_enc_cfg.svh"
module sync_tone_mapper
   import sync_enc_pkg::*;
#(
   parameter int W = `QAM_UNIT_W
) (
   input wire logic clk,
   input wire logic rstn,
   tone_point_if.mapper tp
);
   logic signed [W-1:0] mag;
   logic signed [W-1:0] x0;
   logic signed [W-1:0] y0;
   logic signed [W-1:0] xr;
   logic signed [W-1:0] yr;
   logic signed [2*W-1:0] px;
   logic signed [2*W-1:0] py;

   // ****************
   // 4-QAM map and quadrant rotation
   // ****************
   always_comb begin
      // init symbols use the PSD-level scale, showtime the per-tone gain product
      mag = tp.initMode ? tp.psdScale : tp.gain;
      x0 = tp.frameBit ? -mag : mag; // both bits equal: 00 or 11
      y0 = tp.frameBit ? -mag : mag;
      case (tp.rot) // rotation by multiples of 90 degrees
         2'h0: begin xr = x0; yr = y0; end
         2'h1: begin xr = -y0; yr = x0; end
         2'h2: begin xr = -x0; yr = -y0; end
         default: begin xr = y0; yr = -x0; end
      endcase
      px = {{W{xr[W-1]}}, xr};
      py = {{W{yr[W-1]}}, yr};
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         tp.outX <= {W{1'b0}};
         tp.outY <= {W{1'b0}};
         tp.outValid <= 1'b0;
      end else begin
         tp.outValid <= tp.valid;
         if (tp.active) begin
            tp.outX <= px[W-1:0];
            tp.outY <= py[W-1:0];
         end else begin
            // inactive tones get zero, supported or not; masked tones also zero
            tp.outX <= {W{1'b0}};
            tp.outY <= {W{1'b0}};
         end
      end
   end
endmodule

// File: rtl/sync_symbol_encoder.sv
`timescale 1ns/100ps
`include "sync_enc_cfg.svh"
// Function
// - each active tone carries bit pair 00 or 11, same for all, via 4-QAM.
// - each active point rotated by its tone's 2-bit quadrant scrambler value.
// - quadrant scrambler restarted (reset mode) at every sync symbol.
// - pilot tones are never inserted into sync symbols.
// - in showtime, reconfiguration timing is signalled by inverting the sync frame.
// - supported but inactive, unmasked tones may carry any point.
// - sync points use same gain, normalization and shaping as data.
// - one sync symbol per 257 symbols, after every 256 data symbols.
// - as responder, emit polarity inversion when reconfiguration takes effect.
// - polarity held on later sync symbols until next marker.
// - first showtime sync symbol carries all ones.
// - training: five ones, five zeros, five ones sync symbols.
// - initialization points scaled to the applicable PSD level.
module sync_symbol_encoder
   import sync_enc_pkg::*;
#(
   parameter int W = `QAM_UNIT_W,
   parameter int PERIOD = `SYMS_PER_PERIOD,
   parameter int SEG_LEN = `TRAIN_SEG_LEN
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic showtimeStart,
   input wire logic trainStart,
   input wire logic symbolStart,
   input wire logic reconfigMark,
   input wire logic toneValid,
   input wire logic toneLast,
   input wire logic toneActive,
   input wire logic toneSupported,
   input wire logic toneMasked,
   input wire logic tonePilot,
   input wire logic [1:0] scramblerQuad,
   input wire logic [W-1:0] toneGain,
   input wire logic [W-1:0] psdScale,
   output logic scramblerReset,
   output logic syncSymbol,
   output logic trainDone,
   output logic framePolarity,
   output logic pointValid,
   output logic [W-1:0] pointX,
   output logic [W-1:0] pointY,
   output logic pilotInsert
);
   localparam int CW = $clog2(PERIOD);
   localparam int TW = $clog2(SEG_LEN * `TRAIN_SEGS + 1);
   // the sync slot is the last index of the period, so a shortened PERIOD keeps its spacing
   localparam logic [CW-1:0] LAST_DATA = CW'(PERIOD - 1);
   localparam logic [TW-1:0] TRAIN_LEN = TW'(SEG_LEN * `TRAIN_SEGS);
   localparam logic [TW-1:0] SEG = TW'(SEG_LEN);

   // ****************
   // state
   // ****************
   enc_mode_e mode;
   logic [CW-1:0] symCount;
   logic [TW-1:0] trainCount;
   logic polarity;
   logic markPending;
   logic inSync;
   logic syncEntry;
   logic curFrame;
   logic [1:0] rotD;
   logic validD;
   logic activeD;
   logic supD;
   logic maskD;
   logic [W-1:0] gainD;
   logic [W-1:0] psdD;
   logic frameD;
   logic initD;
   tone_point_if #(.W(W)) tp();

   // ****************
   // training pattern
   // ****************
   // training frame pattern: middle segment of zeros
   function automatic logic train_frame(input logic [TW-1:0] idx);
      return !(idx >= SEG && idx < SEG + SEG);
   endfunction

   // ****************
   // mode and symbol counting
   // ****************
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mode <= MODE_IDLE;
         symCount <= '0;
         trainCount <= '0;
      end else if (showtimeStart) begin
         mode <= MODE_SHOW;
         symCount <= '0;
      end else if (trainStart) begin
         mode <= MODE_TRAIN;
         trainCount <= '0;
      end else if (symbolStart) begin
         case (mode)
            MODE_SHOW: symCount <= (symCount == LAST_DATA) ? '0 : symCount + 1'b1;
            MODE_TRAIN: begin
               if (trainCount == TRAIN_LEN - 1'b1)
                  mode <= MODE_IDLE;
               trainCount <= trainCount + 1'b1;
            end
            default: ;
         endcase
      end
   end

   // ****************
   // sync symbol decode
   // ****************
   // symbol index 256 of each period is the sync symbol, after 256 data symbols
   assign inSync = (mode == MODE_TRAIN) || (mode == MODE_SHOW && symCount == LAST_DATA);
   // looks at the symbol being entered, so the scrambler restarts as the sync symbol opens
   assign syncEntry = !showtimeStart && (trainStart || (symbolStart &&
      ((mode == MODE_SHOW && symCount == LAST_DATA - 1'b1) ||
      (mode == MODE_TRAIN && trainCount != TRAIN_LEN - 1'b1))));
   assign curFrame = (mode == MODE_TRAIN) ? train_frame(trainCount) : polarity;

   // ****************
   // sync frame polarity
   // ****************
   // a marker request arms a toggle applied at the next sync symbol boundary, so a request
   // landing mid-period is never lost and never splits a symbol
   always_ff @(posedge clk) begin
      if (!rstn) begin
         polarity <= `FRAME_ONES;
         markPending <= 1'b0;
      end else if (showtimeStart) begin
         polarity <= `FRAME_ONES;
         markPending <= 1'b0;
      end else begin
         if (symbolStart && mode == MODE_SHOW && symCount == LAST_DATA - 1'b1 && (markPending || reconfigMark)) begin
            polarity <= ~polarity;
            markPending <= 1'b0;
         end else if (reconfigMark && mode == MODE_SHOW) begin
            markPending <= 1'b1; // held otherwise
         end
      end
   end

   // ****************
   // status outputs
   // ****************
   always_ff @(posedge clk) begin
      if (!rstn) begin
         scramblerReset <= 1'b0;
         syncSymbol <= 1'b0;
         trainDone <= 1'b0;
         framePolarity <= `FRAME_ONES;
         pilotInsert <= 1'b0;
      end else begin
         scramblerReset <= syncEntry;
         syncSymbol <= inSync;
         trainDone <= symbolStart && mode == MODE_TRAIN && trainCount == TRAIN_LEN - 1'b1;
         framePolarity <= curFrame;
         pilotInsert <= toneValid && tonePilot && mode == MODE_SHOW && !inSync;
      end
   end

   // ****************
   // tone stage registers
   // ****************
   always_ff @(posedge clk) begin
      if (!rstn) begin
         validD <= 1'b0;
         activeD <= 1'b0;
         supD <= 1'b0;
         maskD <= 1'b0;
         rotD <= 2'h0;
         gainD <= '0;
         psdD <= '0;
         frameD <= 1'b0;
         initD <= 1'b0;
      end else begin
         validD <= toneValid && inSync;
         activeD <= toneActive;
         supD <= toneSupported;
         maskD <= toneMasked;
         rotD <= scramblerQuad;
         gainD <= toneGain;
         psdD <= psdScale;
         frameD <= curFrame;
         initD <= mode == MODE_TRAIN;
      end
   end

   // ****************
   // mapper stage
   // ****************
   assign tp.valid = validD;
   assign tp.frameBit = frameD;
   assign tp.rot = rotD;
   assign tp.active = activeD && !maskD;
   assign tp.supported = supD;
   assign tp.masked = maskD;
   assign tp.initMode = initD;
   assign tp.gain = gainD;
   assign tp.psdScale = psdD;

   sync_tone_mapper #(.W(W)) u_map (
      .clk(clk),
      .rstn(rstn),
      .tp(tp)
   );

   // ****************
   // point outputs
   // ****************
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pointValid <= 1'b0;
         pointX <= '0;
         pointY <= '0;
      end else begin
         pointValid <= tp.outValid;
         pointX <= tp.outX;
         pointY <= tp.outY;
      end
   end
endmodule

// File: tb/sync_symbol_encoder_assertions.sv
`timescale 1ns/100ps
module sync_symbol_encoder_assertions #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic toneValid,
   input wire logic toneActive,
   input wire logic toneMasked,
   input wire logic [1:0] scramblerQuad,
   input wire logic scramblerReset,
   input wire logic syncSymbol,
   input wire logic framePolarity,
   input wire logic pointValid,
   input wire logic [W-1:0] pointX,
   input wire logic [W-1:0] pointY,
   input wire logic pilotInsert
);
   // ****
   // checks
   // ****
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   reset_state_a: assert property ($rose(rstn) |-> framePolarity && !syncSymbol && !pointValid)
      else $error("outputs not at reset values");
   point_latency_a: assert property (toneValid && syncSymbol |-> ##3 pointValid)
      else $error("tone point missing");
   only_sync_a: assert property (pointValid |-> $past(toneValid, 3) && $past(syncSymbol, 3))
      else $error("point outside a sync symbol");
   no_pilot_a: assert property (pointValid |-> !pilotInsert)
      else $error("pilot inserted in sync symbol");
   scram_reset_a: assert property ($rose(syncSymbol) |-> scramblerReset || $past(scramblerReset))
      else $error("scrambler not reset at sync start");
   idle_zero_a: assert property (pointValid && !$past(toneActive, 3) |-> pointX == 0 && pointY == 0)
      else $error("inactive tone not zero");
   quad_rot_a: assert property (pointValid && $past(toneActive, 3) && !$past(toneMasked, 3)
      |-> (pointX == pointY) == !$past(scramblerQuad[0], 3)) else $error("rotation wrong");
   frame_sign_a: assert property (pointValid && $past(toneActive, 3) && !$past(toneMasked, 3)
      && $past(scramblerQuad, 3) == 2'h0 |-> pointX[W-1] == framePolarity) else $error("frame bit wrong");
endmodule
bind sync_symbol_encoder sync_symbol_encoder_assertions #(.W(W)) chk_u (.clk, .rstn, .toneValid, .toneActive,
   .toneMasked, .scramblerQuad, .scramblerReset, .syncSymbol, .framePolarity, .pointValid, .pointX, .pointY,
   .pilotInsert);

// File: tb/point_sink.sv
`timescale 1ns/100ps
module point_sink #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic pointValid,
   input wire logic [W-1:0] pointX,
   input wire logic [W-1:0] pointY
);
   logic [W-1:0] qx[$];
   logic [W-1:0] qy[$];
   // the transform input takes a point every cycle, so no back-pressure exists
   always @(posedge clk) begin
      if (pointValid) begin
         qx.push_back(pointX);
         qy.push_back(pointY);
      end
   end
endmodule

// File: tb/tb_sync_symbol_encoder.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin totalChecks++; if ((s) !== (e)) begin errors++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_sync_symbol_encoder;
   import sync_enc_pkg::*;
   localparam int W = 16;
   localparam int P = 9;
   typedef struct {logic act; logic msk; logic [1:0] q; int ex; int ey;} row_s;
   // short period keeps the run small; sync spacing is derived from P
   row_s rows[6] = '{'{1, 0, 0, 1, 1}, '{1, 0, 1, -1, 1}, '{1, 0, 2, -1, -1}, '{1, 0, 3, 1, -1},
      '{1, 1, 1, 0, 0}, '{0, 0, 2, 0, 0}};
   logic clk = 0, rstn, showtimeStart, trainStart, symbolStart, reconfigMark, toneValid, toneLast;
   logic toneActive, toneSupported, toneMasked, tonePilot, scramblerReset, syncSymbol, trainDone;
   logic framePolarity, pointValid, pilotInsert, sawDone = 0;
   logic [1:0] scramblerQuad;
   logic [W-1:0] toneGain, psdScale, pointX, pointY;
   int errors = 0, totalChecks = 0;
   always #12.5 clk = ~clk;
   always @(posedge clk) if (trainDone) sawDone <= 1;
   sync_symbol_encoder #(.W(W), .PERIOD(P)) dut_u (.clk, .rstn, .showtimeStart, .trainStart, .symbolStart,
      .reconfigMark, .toneValid, .toneLast, .toneActive, .toneSupported, .toneMasked, .tonePilot, .scramblerQuad,
      .toneGain, .psdScale, .scramblerReset, .syncSymbol, .trainDone, .framePolarity, .pointValid, .pointX,
      .pointY, .pilotInsert);
   point_sink #(.W(W)) sink_u (.clk, .pointValid, .pointX, .pointY);
   task automatic conclude();
      if (errors == 0 && totalChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic starts(input int n);
      repeat (n) begin
         @(posedge clk) symbolStart <= 1;
         @(posedge clk) symbolStart <= 0;
         repeat (2) @(posedge clk);
      end
      #1;
   endtask
   task automatic sendRows(input logic ones, input logic [W-1:0] m);
      int b;
      b = ones ? -int'(m) : int'(m);
      foreach (rows[i]) begin
         @(posedge clk) toneValid <= 1;
         toneActive <= rows[i].act;
         toneMasked <= rows[i].msk;
         scramblerQuad <= rows[i].q;
         toneLast <= (i == 5);
      end
      @(posedge clk) toneValid <= 0;
      toneLast <= 0;
      #1;
      `CHK("pilot", 1'b0, pilotInsert)
      repeat (5) @(posedge clk);
      #1;
      `CHK("count", 6, sink_u.qx.size())
      foreach (rows[i]) begin
         `CHK("x", W'(rows[i].ex * b), sink_u.qx[i])
         `CHK("y", W'(rows[i].ey * b), sink_u.qy[i])
      end
      sink_u.qx.delete();
      sink_u.qy.delete();
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      conclude();
   end
   initial begin
      {rstn, showtimeStart, trainStart, symbolStart, reconfigMark, toneValid, toneLast, toneActive} = 0;
      {toneMasked, scramblerQuad} = 0;
      {toneSupported, tonePilot} = 2'b11;
      toneGain = 16'h0100;
      psdScale = 16'h0040;
      repeat (8) @(posedge clk);
      rstn <= 1;
      @(posedge clk) #1;
      `CHK("polarity", 1'b1, framePolarity)
      `CHK("sync", 1'b0, syncSymbol)
      // a tone in a data symbol must be dropped; the count check below sees it
      @(posedge clk) showtimeStart <= 1;
      @(posedge clk) showtimeStart <= 0;
      toneValid <= 1;
      @(posedge clk) toneValid <= 0;
      #1;
      `CHK("pilot", 1'b1, pilotInsert)
      starts(P - 2);
      `CHK("sync", 1'b0, syncSymbol)
      starts(1);
      `CHK("sync", 1'b1, syncSymbol)
      `CHK("polarity", 1'b1, framePolarity)
      sendRows(1, toneGain);
      starts(1);
      @(posedge clk) reconfigMark <= 1;
      @(posedge clk) reconfigMark <= 0;
      starts(P - 1);
      `CHK("polarity", 1'b0, framePolarity)
      sendRows(0, toneGain);
      starts(P);
      `CHK("polarity", 1'b0, framePolarity)
      @(posedge clk) showtimeStart <= 1;
      @(posedge clk) showtimeStart <= 0;
      @(posedge clk) #1;
      `CHK("polarity", 1'b1, framePolarity)
      @(posedge clk) trainStart <= 1;
      @(posedge clk) trainStart <= 0;
      repeat (2) @(posedge clk);
      #1;
      for (int i = 0; i < 15; i++) begin
         `CHK("polarity", logic'(i / 5 != 1), framePolarity)
         `CHK("done", 1'b0, sawDone)
         sendRows(i / 5 != 1, psdScale);
         starts(1);
      end
      `CHK("done", 1'b1, sawDone)
      conclude();
   end
endmodule
